// >>> logic/mta_map.vh
// Constants for the transmit mover and packet memory arbiter.
// Functional notes
// - Arbiter levels 0..2: receive high, transmit high, then CPU.
// - Levels 3 and 4: receive low, then transmit low, lowest of all.
// - On each poll timer expiry while idle read high status byte at the read pointer.
// - Keep polling until owner bit 7 of high status byte (bit 15) is one.
// - On ownership load length counter from descriptor bytes 3 and 4.
// - Copy bytes into transmit queue, decrement length, stop at zero.
// - After last byte wait for transmission complete from the MAC.
// - Write transmit status into descriptor and clear owner bit 15.
// - Then set the transmit complete interrupt status flag.
// - Load memory pointer from the current next descriptor link.
// - Read next descriptor high status byte to look for more work.
// - While filling, watch repeat and drop requests from queue controller.
// - On drop, write descriptor status and advance to next packet.
// - On repeat, rewind to packet start, reload length, refill queue.
// - On drop or repeat, pulse queue pointer clear to discard queued data.
`ifndef MTA_MAP_VH
`define MTA_MAP_VH

// APB register byte offsets.
`define MTA_REG_CTRL      8'h00
`define MTA_REG_POLL      8'h04
`define MTA_REG_RDPTR     8'h08
`define MTA_REG_STATE     8'h0C
`define MTA_REG_ISTAT     8'h10
`define MTA_REG_IMASK     8'h14

// Reset values.
`define MTA_CTRL_RST      1'b0
`define MTA_POLL_RST      16'h0100
`define MTA_RDPTR_RST     16'h0000
`define MTA_IMASK_RST     3'h0

// Interrupt status bit positions.
`define MTA_INT_DONE      0
`define MTA_INT_DROP      1
`define MTA_INT_REPEAT    2

// Descriptor byte offsets and owner bit position in the high status byte.
`define MTA_DSC_LINK_LO   16'h0000
`define MTA_DSC_LINK_HI   16'h0001
`define MTA_DSC_LEN_LO    16'h0003
`define MTA_DSC_LEN_HI    16'h0004
`define MTA_DSC_STAT_LO   16'h0005
`define MTA_DSC_STAT_HI   16'h0006
`define MTA_DSC_DATA      16'h0008
`define MTA_OWNER_BIT     7

`endif

// >>> logic/mta_top.v
// Transmit descriptor mover with packet memory priority arbiter and APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "mta_map.vh"

module mta_top (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Interrupt.
  output reg         irq,
  // Other packet memory masters.
  input  wire        rx_mem_req,
  input  wire        rx_queue_above_half,
  input  wire        rx_queue_below_half,
  output reg         rx_mem_gnt,
  input  wire        cpu_mem_req,
  output reg         cpu_mem_gnt,
  // Packet memory port of the transmit mover.
  output reg  [15:0] tx_mem_addr,
  output reg         tx_mem_rd,
  output reg         tx_mem_wr,
  output reg  [7:0]  tx_mem_wdata,
  input  wire [7:0]  tx_mem_rdata,
  // Transmit queue.
  output reg         tx_queue_push,
  output reg  [7:0]  tx_queue_data,
  input  wire        tx_queue_full,
  input  wire        tx_queue_above_half,
  input  wire        tx_queue_below_half,
  // Queue controller handshake and MAC completion.
  input  wire        tx_repeat_request,
  input  wire        tx_drop_request,
  output reg         tx_queue_pointer_clear_done,
  input  wire        tx_complete,
  input  wire [7:0]  tx_status
);

  // ****************************************************************
  // Mover states, one-hot.
  // ****************************************************************
  localparam [11:0] S_IDLE   = 12'h001;
  localparam [11:0] S_POLL   = 12'h002;
  localparam [11:0] S_LEN_LO = 12'h004;
  localparam [11:0] S_LEN_HI = 12'h008;
  localparam [11:0] S_LNK_LO = 12'h010;
  localparam [11:0] S_LNK_HI = 12'h020;
  localparam [11:0] S_RD     = 12'h040;
  localparam [11:0] S_PUSH   = 12'h080;
  localparam [11:0] S_WAIT   = 12'h100;
  localparam [11:0] S_ST_LO  = 12'h200;
  localparam [11:0] S_ST_HI  = 12'h400;
  localparam [11:0] S_FLUSH  = 12'h800;

  // Fixed priority pick: {rx, tx, cpu} one-hot from the five levels.
  function [2:0] mta_pick;
    input rx_r;
    input rx_hi;
    input tx_r;
    input tx_lo;
    input cpu_r;
    begin
      if (rx_r && rx_hi)
        mta_pick = 3'h4;
      else if (tx_r && tx_lo)
        mta_pick = 3'h2;
      else if (cpu_r)
        mta_pick = 3'h1;
      else if (rx_r)
        mta_pick = 3'h4;
      else if (tx_r)
        mta_pick = 3'h2;
      else
        mta_pick = 3'h0;
    end
  endfunction

  // ****************************************************************
  // Registers and state.
  // ****************************************************************
  reg        enable_ff;
  reg [15:0] poll_period_ff;
  reg [15:0] poll_cnt_ff;
  reg        poll_exp_ff;
  reg [15:0] rdptr_ff;
  reg [2:0]  istat_ff;
  reg [2:0]  imask_ff;
  reg [11:0] state_ff;
  reg [15:0] len_ff;
  reg [15:0] size_ff;
  reg [15:0] link_ff;
  reg [15:0] ptr_ff;
  reg [7:0]  stat_hi_ff;
  reg [7:0]  byte_ff;
  reg        busy_ff;
  reg        issue_ff;
  reg        rdv_ff;
  reg        drop_ff;

  wire       wr_acc = psel && penable && pready && pwrite;
  wire       tx_req;
  wire [2:0] pick;
  wire       is_rd;
  reg [15:0] req_addr;
  reg [7:0]  req_wdata;
  reg        req_write;

  // A memory access is requested only in access states, once per step.
  assign is_rd  = (state_ff == S_POLL) || (state_ff == S_LEN_LO) || (state_ff == S_LEN_HI) ||
                  (state_ff == S_LNK_LO) || (state_ff == S_LNK_HI) || (state_ff == S_RD);
  assign tx_req = !busy_ff && (is_rd || (state_ff == S_ST_LO) || (state_ff == S_ST_HI));

  // The two level-pair sources feed the pick; exactly half full falls to low. 
  assign pick = mta_pick(rx_mem_req, rx_queue_above_half, tx_req,
                         tx_queue_below_half, cpu_mem_req);

  // ****************************************************************
  // Address and data of the mover's pending access.
  // ****************************************************************
  always @* begin
    req_write = 1'b0;
    req_wdata = 8'h00;
    case (state_ff)
      S_POLL:   req_addr = rdptr_ff + `MTA_DSC_STAT_HI;
      S_LEN_LO: req_addr = rdptr_ff + `MTA_DSC_LEN_LO;
      S_LEN_HI: req_addr = rdptr_ff + `MTA_DSC_LEN_HI;
      S_LNK_LO: req_addr = rdptr_ff + `MTA_DSC_LINK_LO;
      S_LNK_HI: req_addr = rdptr_ff + `MTA_DSC_LINK_HI;
      S_ST_LO: begin
        req_addr  = rdptr_ff + `MTA_DSC_STAT_LO;
        req_write = 1'b1;
        req_wdata = tx_status;
      end
      S_ST_HI: begin
        req_addr  = rdptr_ff + `MTA_DSC_STAT_HI;
        req_write = 1'b1;
        req_wdata = stat_hi_ff & 8'h7F;
      end
      default:  req_addr = ptr_ff;
    endcase
  end

  // ****************************************************************
  // Arbiter grants and the mover's memory strobes.
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_mem_gnt   <= 1'b0;
      cpu_mem_gnt  <= 1'b0;
      tx_mem_addr  <= 16'h0000;
      tx_mem_rd    <= 1'b0;
      tx_mem_wr    <= 1'b0;
      tx_mem_wdata <= 8'h00;
      issue_ff     <= 1'b0;
      rdv_ff       <= 1'b0;
    end else begin
      rx_mem_gnt  <= pick[2];
      cpu_mem_gnt <= pick[0];
      tx_mem_rd   <= pick[1] && !req_write;
      tx_mem_wr   <= pick[1] && req_write;
      issue_ff    <= pick[1];
      // Read data returns one cycle after the strobe.
      rdv_ff      <= issue_ff && tx_mem_rd;
      if (pick[1]) begin
        tx_mem_addr  <= req_addr;
        tx_mem_wdata <= req_wdata;
      end
    end
  end

  // ****************************************************************
  // Poll timer: a one-cycle expiry pulse every period plus one cycles.
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_cnt_ff <= `MTA_POLL_RST;
      poll_exp_ff <= 1'b0;
    end else begin
      poll_exp_ff <= 1'b0;
      if (!enable_ff)
        poll_cnt_ff <= poll_period_ff;
      else if (poll_cnt_ff == 16'h0000) begin
        poll_cnt_ff <= poll_period_ff;
        poll_exp_ff <= 1'b1;
      end else
        poll_cnt_ff <= poll_cnt_ff - 16'h0001;
    end
  end

  // ****************************************************************
  // Transmit mover state machine.
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff                    <= S_IDLE;
      len_ff                      <= 16'h0000;
      size_ff                     <= 16'h0000;
      link_ff                     <= 16'h0000;
      ptr_ff                      <= 16'h0000;
      stat_hi_ff                  <= 8'h00;
      byte_ff                     <= 8'h00;
      busy_ff                     <= 1'b0;
      drop_ff                     <= 1'b0;
      rdptr_ff                    <= `MTA_RDPTR_RST;
      tx_queue_push               <= 1'b0;
      tx_queue_data               <= 8'h00;
      tx_queue_pointer_clear_done <= 1'b0;
    end else begin
      tx_queue_push <= 1'b0;
      if (pick[1])
        busy_ff <= 1'b1;
      if (rdv_ff || (issue_ff && tx_mem_wr))
        busy_ff <= 1'b0;
      // Software may move the read pointer only while the mover is idle.
      if (wr_acc && (paddr == `MTA_REG_RDPTR) && (state_ff == S_IDLE))
        rdptr_ff <= pwdata[15:0];
      case (state_ff)
        S_IDLE: begin
          if (enable_ff && poll_exp_ff)
            state_ff <= S_POLL;
        end
        S_POLL: begin
          if (rdv_ff) begin
            stat_hi_ff <= tx_mem_rdata;
            if (tx_mem_rdata[`MTA_OWNER_BIT])
              state_ff <= S_LEN_LO;
            else
              state_ff <= S_IDLE;
          end
        end
        S_LEN_LO: begin
          if (rdv_ff) begin
            size_ff[7:0] <= tx_mem_rdata;
            state_ff     <= S_LEN_HI;
          end
        end
        S_LEN_HI: begin
          if (rdv_ff) begin
            size_ff[15:8] <= tx_mem_rdata;
            len_ff        <= {tx_mem_rdata, size_ff[7:0]};
            ptr_ff        <= rdptr_ff + `MTA_DSC_DATA;
            state_ff      <= S_LNK_LO;
          end
        end
        S_LNK_LO: begin
          if (rdv_ff) begin
            link_ff[7:0] <= tx_mem_rdata;
            state_ff     <= S_LNK_HI;
          end
        end
        S_LNK_HI: begin
          if (rdv_ff) begin
            link_ff[15:8] <= tx_mem_rdata;
            state_ff      <= (len_ff == 16'h0000) ? S_WAIT : S_RD;
          end
        end
        S_RD: begin
          if (tx_drop_request || tx_repeat_request) begin
            // Wait for any read in flight so the busy flag is clean.
            if (!busy_ff) begin
              drop_ff                     <= tx_drop_request;
              tx_queue_pointer_clear_done <= 1'b1;
              state_ff                    <= S_FLUSH;
            end
          end else if (rdv_ff) begin
            byte_ff  <= tx_mem_rdata;
            state_ff <= S_PUSH;
          end
        end
        S_PUSH: begin
          if (tx_drop_request || tx_repeat_request) begin
            drop_ff                     <= tx_drop_request;
            tx_queue_pointer_clear_done <= 1'b1;
            state_ff                    <= S_FLUSH;
          end else if (!tx_queue_full) begin
            // A full queue stalls the copy instead of losing the byte.
            tx_queue_push <= 1'b1;
            tx_queue_data <= byte_ff;
            ptr_ff        <= ptr_ff + 16'h0001;
            len_ff        <= len_ff - 16'h0001;
            state_ff      <= (len_ff == 16'h0001) ? S_WAIT : S_RD;
          end
        end
        S_WAIT: begin
          if (tx_drop_request || tx_repeat_request) begin
            drop_ff                     <= tx_drop_request;
            tx_queue_pointer_clear_done <= 1'b1;
            state_ff                    <= S_FLUSH;
          end else if (tx_complete)
            state_ff <= S_ST_LO;
        end
        S_FLUSH: begin
          // Clear stays high until the controller drops both requests.
          if (!tx_drop_request && !tx_repeat_request) begin
            tx_queue_pointer_clear_done <= 1'b0;
            if (drop_ff)
              state_ff <= S_ST_LO;
            else begin
              ptr_ff   <= rdptr_ff + `MTA_DSC_DATA;
              len_ff   <= size_ff;
              state_ff <= (size_ff == 16'h0000) ? S_WAIT : S_RD;
            end
          end
        end
        S_ST_LO: begin
          if (issue_ff && tx_mem_wr)
            state_ff <= S_ST_HI;
        end
        S_ST_HI: begin
          if (issue_ff && tx_mem_wr) begin
            rdptr_ff <= link_ff;
            drop_ff  <= 1'b0;
            state_ff <= S_POLL;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // APB registers, interrupt status and mask.
  // ****************************************************************
  wire       done_ev  = (state_ff == S_ST_HI) && issue_ff && tx_mem_wr;
  // The flush ends in the one cycle with both requests low, so each cause is flagged once.
  wire       flush_exit = (state_ff == S_FLUSH) && !tx_drop_request && !tx_repeat_request;
  wire [2:0] set_ev;
  wire [2:0] clr_ev;
  assign set_ev = {flush_exit && !drop_ff,
                   flush_exit && drop_ff,
                   done_ev && !drop_ff};
  assign clr_ev = (wr_acc && (paddr == `MTA_REG_ISTAT)) ? pwdata[2:0] : 3'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff      <= `MTA_CTRL_RST;
      poll_period_ff <= `MTA_POLL_RST;
      imask_ff       <= `MTA_IMASK_RST;
      istat_ff       <= 3'h0;
      irq            <= 1'b0;
    end else begin
      if (wr_acc && (paddr == `MTA_REG_CTRL))
        enable_ff <= pwdata[0];
      if (wr_acc && (paddr == `MTA_REG_POLL))
        poll_period_ff <= pwdata[15:0];
      if (wr_acc && (paddr == `MTA_REG_IMASK))
        imask_ff <= pwdata[2:0];
      // Set wins over a clear written in the same cycle.
      istat_ff <= (istat_ff & ~clr_ev) | set_ev;
      irq      <= |(((istat_ff & ~clr_ev) | set_ev) & imask_ff);
    end
  end

  // Read data and ready are prepared in the setup cycle: zero wait states.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `MTA_REG_CTRL:  prdata <= {31'h0000_0000, enable_ff};
          `MTA_REG_POLL:  prdata <= {16'h0000, poll_period_ff};
          `MTA_REG_RDPTR: prdata <= {16'h0000, rdptr_ff};
          `MTA_REG_STATE: prdata <= {4'h0, state_ff, len_ff};
          `MTA_REG_ISTAT: prdata <= {29'h0000_0000, istat_ff};
          `MTA_REG_IMASK: prdata <= {29'h0000_0000, imask_ff};
          default:        pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // mta_top
`default_nettype wire

// >>> testbench/mta_checker.sv
// Port checker for the transmit mover and packet memory arbiter.
`timescale 1ns/1ps
`default_nettype none
module mta_checker (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus and memory arbiter.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic rx_mem_req,
  input wire logic rx_queue_above_half,
  input wire logic rx_mem_gnt,
  input wire logic cpu_mem_req,
  input wire logic cpu_mem_gnt,
  // Transmit queue handshake.
  input wire logic tx_queue_push,
  input wire logic tx_repeat_request,
  input wire logic tx_drop_request,
  input wire logic tx_queue_pointer_clear_done
);
  // ****************************************
  // Properties, all on the one bus clock.
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_rx_high_wins: assert property (rx_mem_req && rx_queue_above_half |=> rx_mem_gnt && !cpu_mem_gnt)
    else $error("urgent receive not granted first");
  a_cpu_gnt_cause: assert property (cpu_mem_gnt |-> $past(cpu_mem_req) && !$past(rx_mem_req && rx_queue_above_half))
    else $error("processor grant without cause");
  a_rx_gnt_cause: assert property (rx_mem_gnt |-> $past(rx_mem_req))
    else $error("receive grant without request");
  a_cpu_over_rxlow: assert property (cpu_mem_req && !rx_queue_above_half |=> !rx_mem_gnt)
    else $error("relaxed receive beat processor");
  a_push_single: assert property (tx_queue_push |=> !tx_queue_push)
    else $error("push held two cycles");
  a_clear_answer: assert property ($rose(tx_drop_request || tx_repeat_request) |-> ##[1:4] tx_queue_pointer_clear_done)
    else $error("pointer clear did not answer");
  a_clear_hold: assert property (tx_queue_pointer_clear_done && (tx_drop_request || tx_repeat_request) |=> tx_queue_pointer_clear_done)
    else $error("pointer clear fell early");
  a_clear_fall: assert property (tx_queue_pointer_clear_done && !tx_drop_request && !tx_repeat_request |=> !tx_queue_pointer_clear_done)
    else $error("pointer clear stuck high");
  a_no_push_clear: assert property (tx_queue_pointer_clear_done ##1 tx_queue_pointer_clear_done |-> !tx_queue_push)
    else $error("push while queue is cleared");
endmodule // mta_checker

bind mta_top mta_checker u_mta_checker (
  .pclk, .presetn, .psel, .penable, .pready, .rx_mem_req, .rx_queue_above_half,
  .rx_mem_gnt, .cpu_mem_req, .cpu_mem_gnt, .tx_queue_push, .tx_repeat_request,
  .tx_drop_request, .tx_queue_pointer_clear_done
);
`default_nettype wire

// >>> testbench/mta_partner.sv
// Packet memory and transmit queue controller model facing the mover.
`timescale 1ns/1ps
`default_nettype none
module mta_partner (
  // Clock, reset and scenario command (bit 0 repeat, bit 1 drop).
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [1:0]  cmd,
  // Packet memory port.
  input  wire logic [15:0] tx_mem_addr,
  input  wire logic        tx_mem_rd,
  input  wire logic        tx_mem_wr,
  input  wire logic [7:0]  tx_mem_wdata,
  output var  logic [7:0]  tx_mem_rdata,
  // Transmit queue and handshake.
  input  wire logic        tx_queue_push,
  output wire logic        tx_queue_full,
  output wire logic        tx_queue_above_half,
  output wire logic        tx_queue_below_half,
  output var  logic        tx_repeat_request,
  output var  logic        tx_drop_request,
  input  wire logic        tx_queue_pointer_clear_done
);
  logic [7:0] mem [0:255];
  logic [3:0] cnt;
  logic [2:0] tick;

  // Level flags; exactly half raises neither.
  assign tx_queue_full       = (cnt == 4'h8);
  assign tx_queue_above_half = (cnt > 4'h4);
  assign tx_queue_below_half = (cnt < 4'h4);

  // Read data is valid only the cycle after a strobe, then it keeps changing.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mem_rdata <= 8'h00;
      cnt <= 4'h0;
      tick <= 3'h0;
      tx_repeat_request <= 1'h0;
      tx_drop_request <= 1'h0;
    end else begin
      if (tx_mem_wr) begin
        mem[tx_mem_addr[7:0]] <= tx_mem_wdata;
      end
      tx_mem_rdata <= tx_mem_rd ? mem[tx_mem_addr[7:0]] : ~tx_mem_rdata;
      tick <= tick + 3'h1;
      // Drain slowly so the level flags move.
      if (tx_queue_pointer_clear_done) begin
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + {3'h0, tx_queue_push} - {3'h0, (tick == 3'h0) && (cnt != 4'h0)};
      end
      // Requests stay up until the clear indication, then both fall.
      if (tx_queue_pointer_clear_done) begin
        {tx_drop_request, tx_repeat_request} <= 2'h0;
      end else begin
        {tx_drop_request, tx_repeat_request} <= {tx_drop_request, tx_repeat_request} | cmd;
      end
    end
  end
endmodule // mta_partner
`default_nettype wire

// >>> testbench/test_mac_tx_dma_arbiter.sv
// Self-checking testbench for the transmit mover and memory arbiter.
`timescale 1ns/1ps
`default_nettype none
module test_mac_tx_dma_arbiter;
  logic        pclk, presetn, psel, penable, pwrite, tx_complete;
  logic        rx_mem_req, rx_queue_above_half, rx_queue_below_half, cpu_mem_req;
  logic [7:0]  paddr, tx_status;
  logic [31:0] pwdata;
  logic [1:0]  cmd;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, irq, rx_mem_gnt, cpu_mem_gnt, tx_mem_rd, tx_mem_wr;
  wire logic        tx_queue_push, tx_queue_full, tx_queue_above_half, tx_queue_below_half;
  wire logic        tx_repeat_request, tx_drop_request, tx_queue_pointer_clear_done;
  wire logic [15:0] tx_mem_addr;
  wire logic [7:0]  tx_mem_wdata, tx_mem_rdata, tx_queue_data;
  logic [7:0]  exp_q[$];
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;

  mta_top u_mta_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .rx_mem_req, .rx_queue_above_half, .rx_queue_below_half,
    .rx_mem_gnt, .cpu_mem_req, .cpu_mem_gnt, .tx_mem_addr, .tx_mem_rd, .tx_mem_wr,
    .tx_mem_wdata, .tx_mem_rdata, .tx_queue_push, .tx_queue_data, .tx_queue_full,
    .tx_queue_above_half, .tx_queue_below_half, .tx_repeat_request, .tx_drop_request,
    .tx_queue_pointer_clear_done, .tx_complete, .tx_status);
  mta_partner u_mta_partner (.pclk, .presetn, .cmd, .tx_mem_addr, .tx_mem_rd, .tx_mem_wr,
    .tx_mem_wdata, .tx_mem_rdata, .tx_queue_push, .tx_queue_full, .tx_queue_above_half,
    .tx_queue_below_half, .tx_repeat_request, .tx_drop_request, .tx_queue_pointer_clear_done);

  // ****************************************
  // Helpers: compare, verdict, bus cycle.
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic er);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    if (!w) chk("prdata", e, prdata);
    chk("pslverr", {31'h0, er}, {31'h0, pslverr});
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // Descriptor: link, length, unowned status, random payload.
  task automatic desc(input logic [7:0] b, input logic [7:0] l, input logic [7:0] n);
    u_mta_partner.mem[b] = l;
    u_mta_partner.mem[b + 8'h01] = 8'h00;
    u_mta_partner.mem[b + 8'h03] = n;
    u_mta_partner.mem[b + 8'h04] = 8'h00;
    u_mta_partner.mem[b + 8'h06] = {1'h0, 7'($urandom)};
    for (int i = 0; i < n; i++) u_mta_partner.mem[b + 8'h08 + 8'(i)] = 8'($urandom);
  endtask

  task automatic load(input logic [7:0] b, input int n);
    exp_q.delete();
    for (int i = 0; i < n; i++) exp_q.push_back(u_mta_partner.mem[b + 8'h08 + 8'(i)]);
  endtask

  // Hand one packet to the mover; m is 0 plain, 1 repeat, 2 drop.
  task automatic run_pkt(input logic [7:0] b, input int n, input logic [1:0] m);
    logic [7:0] hi;
    load(b, n);
    u_mta_partner.mem[b + 8'h06][7] = 1'h1;
    hi = u_mta_partner.mem[b + 8'h06];
    if (m != 2'h0) begin
      while (tx_queue_push !== 1'h1) @(posedge pclk);
      cmd <= m;
      @(posedge pclk);
      cmd <= 2'h0;
      while (tx_queue_pointer_clear_done !== 1'h1) @(posedge pclk);
      exp_q.delete();
      if (m == 2'h1) load(b, n);
      while (tx_queue_pointer_clear_done !== 1'h0) @(posedge pclk);
    end
    if (m != 2'h2) begin
      while (exp_q.size() != 0) @(posedge pclk);
      repeat (4) @(posedge pclk);
      tx_complete <= 1'h1;
      @(posedge pclk);
      tx_complete <= 1'h0;
    end
    while (u_mta_partner.mem[b + 8'h06][7] !== 1'h0) @(posedge pclk);
    repeat (4) @(posedge pclk);
    chk("status_hi", {24'h0, hi & 8'h7F}, {24'h0, u_mta_partner.mem[b + 8'h06]});
    chk("status_lo", {24'h0, tx_status}, {24'h0, u_mta_partner.mem[b + 8'h05]});
  endtask

  // Each pushed byte is matched against the oldest note.
  always @(posedge pclk) begin
    if (tx_queue_push === 1'h1) begin
      if (exp_q.size() == 0) chk("push_extra", 32'h1, 32'h0);
      else chk("push_data", {24'h0, exp_q.pop_front()}, {24'h0, tx_queue_data});
    end
  end

  // A hang is cut short well past the expected run length.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    logic [31:0] r;
    {psel, penable, pwrite, paddr, pwdata, cmd, tx_complete, tx_status} = '0;
    {rx_mem_req, rx_queue_above_half, rx_queue_below_half, cpu_mem_req} = '0;
    presetn = 1'h0;
    r = $urandom(45);
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 8'h00, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 8'h04, 32'h0, 32'h100, 1'h0);
    apb(1'h0, 8'h08, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 8'h0C, 32'h0, 32'h0001_0000, 1'h0);
    apb(1'h0, 8'h10, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 8'h14, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 8'h18, 32'h0, 32'h0, 1'h1);
    // Random requests while the mover is off; grant follows the level table.
    for (int i = 0; i < 24; i++) begin
      @(posedge pclk);
      r = $urandom;
      {rx_mem_req, rx_queue_above_half, cpu_mem_req} <= r[2:0];
      rx_queue_below_half <= ~r[1] & r[3];
      @(posedge pclk);
      @(negedge pclk);
      chk("rx_gnt", {31'h0, r[2] & (r[1] | ~r[0])}, {31'h0, rx_mem_gnt});
      chk("cpu_gnt", {31'h0, r[0] & ~(r[2] & r[1])}, {31'h0, cpu_mem_gnt});
    end
    @(posedge pclk);
    {rx_mem_req, cpu_mem_req} <= 2'h0;
    desc(8'h00, 8'h20, 8'h05);
    desc(8'h20, 8'h40, 8'h03);
    desc(8'h40, 8'h60, 8'h04);
    desc(8'h60, 8'h80, 8'h01);
    desc(8'h80, 8'h80, 8'h00);
    tx_status <= 8'($urandom);
    apb(1'h1, 8'h04, 32'h4, 32'h0, 1'h0);
    apb(1'h1, 8'h14, 32'h1, 32'h0, 1'h0);
    apb(1'h1, 8'h00, 32'h1, 32'h0, 1'h0);
    run_pkt(8'h00, 5, 2'h0);
    chk("irq_done", 32'h1, {31'h0, irq});
    apb(1'h0, 8'h10, 32'h0, 32'h1, 1'h0);
    apb(1'h1, 8'h10, 32'h1, 32'h0, 1'h0);
    chk("irq_clear", 32'h0, {31'h0, irq});
    run_pkt(8'h20, 3, 2'h1);
    apb(1'h0, 8'h10, 32'h0, 32'h5, 1'h0);
    apb(1'h1, 8'h10, 32'h7, 32'h0, 1'h0);
    run_pkt(8'h40, 4, 2'h2);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'h0, 8'h10, 32'h0, 32'h2, 1'h0);
    repeat (30) @(posedge pclk);
    run_pkt(8'h60, 1, 2'h0);
    repeat (20) @(posedge pclk);
    end_sim();
  end
endmodule // test_mac_tx_dma_arbiter
`default_nettype wire
